// >>> rtl/uip_pkg.sv
/*
 Package for the per-channel interrupt priority unit: register offsets,
 field positions, reset values, source codes and timing constants.
 Assumes the register bus decode lives outside; offsets are for reference.
*/
package uip_pkg;

   // ----------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] UIP_IER_OFFSET = 4'h1;
   localparam logic [3:0] UIP_ISR_OFFSET = 4'h2;
   localparam logic [7:0] UIP_IER_RESET = 8'h00;
   localparam logic [5:0] UIP_ISR_IDLE = 6'h01;

   // ----------------------------------------------------------------
   // Enable register fields
   // ----------------------------------------------------------------
   localparam int UIP_IE_RX = 0;
   localparam int UIP_IE_TX = 1;
   localparam int UIP_IE_LS = 2;
   localparam int UIP_IE_MS = 3;
   localparam int UIP_IE_SLEEP = 4;
   localparam int UIP_IE_XOFF = 5;
   localparam int UIP_IE_RTS = 6;
   localparam int UIP_IE_CTS = 7;
   localparam int UIP_IE_BASIC_W = 4;
   localparam int UIP_EFR_ENH_BIT = 4;

   // ----------------------------------------------------------------
   // Line status fields
   // ----------------------------------------------------------------
   localparam int UIP_LS_DR = 0;
   localparam int UIP_LS_OE = 1;
   localparam int UIP_LS_PE = 2;
   localparam int UIP_LS_FE = 3;
   localparam int UIP_LS_BI = 4;
   localparam int UIP_LS_THRE = 5;
   localparam int UIP_LS_TEMT = 6;
   localparam int UIP_LS_FERR = 7;

   // ----------------------------------------------------------------
   // Source codes, priority 1 to 8
   // ----------------------------------------------------------------
   localparam logic [5:0] UIP_CODE_LS = 6'h06;
   localparam logic [5:0] UIP_CODE_TMO = 6'h0c;
   localparam logic [5:0] UIP_CODE_RX = 6'h04;
   localparam logic [5:0] UIP_CODE_TX = 6'h02;
   localparam logic [5:0] UIP_CODE_MS = 6'h00;
   localparam logic [5:0] UIP_CODE_GPIO = 6'h30;
   localparam logic [5:0] UIP_CODE_XOFF = 6'h10;
   localparam logic [5:0] UIP_CODE_FLOW = 6'h20;

   // ----------------------------------------------------------------
   // Timeout: 4 characters plus 12 bit times, counted in bit ticks
   // ----------------------------------------------------------------
   localparam int UIP_TMO_CHARS = 4;
   localparam int UIP_TMO_EXTRA_BITS = 12;
   localparam int UIP_GPIO_W = 8;

   typedef enum logic [3:0] {
      UIP_SRC_NONE, UIP_SRC_LS, UIP_SRC_TMO, UIP_SRC_RX, UIP_SRC_TX,
      UIP_SRC_MS, UIP_SRC_GPIO, UIP_SRC_XOFF, UIP_SRC_FLOW
   } uip_src_e;

   // Receive-side status gathered from the FIFO and shift register
   typedef struct packed {
      logic fifo_nonempty;
      logic at_trigger;
      logic head_pe;
      logic head_fe;
      logic head_bi;
      logic any_err;
      logic overrun_pulse;
      logic char_pulse;
   } uip_rx_s;

   // Transmit-side status
   typedef struct packed {
      logic thr_empty;
      logic tx_all_empty;
      logic space_above_trig;
      logic auto_485;
   } uip_tx_s;

endpackage : uip_pkg

// >>> rtl/uip_timeout.sv
/*
 Receive timeout timer. Counts bit ticks while the receive FIFO holds data
 and nothing arrives or is read. Assumes a one-cycle bit tick input.
*/
`timescale 1ns/1ps
module uip_timeout
   import uip_pkg::*;
#(
   parameter int CHAR_BITS_MAX = 12,
   parameter int CNT_W = 8
)
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic bit_tick,
   input wire logic [3:0] char_bits,
   input wire logic fifo_nonempty,
   input wire logic activity,
   output logic expired
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;

   // Limit scales with the programmed character length
   assign limit = CNT_W'(UIP_TMO_CHARS * int'(char_bits) + UIP_TMO_EXTRA_BITS);

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN || !fifo_nonempty || activity)
         cnt_q <= '0;
      else if (bit_tick && cnt_q != limit)
         cnt_q <= cnt_q + CNT_W'(1);
   end

   // One-cycle pulse on the tick that reaches the limit; a level would
   // re-set the flag in the very cycle that the holding read clears it
   assign expired = fifo_nonempty && !activity && bit_tick && (cnt_q == limit - CNT_W'(1));

endmodule // uip_timeout

// >>> rtl/uip_core.sv
/*
 Per-channel interrupt priority unit: enable register, prioritised source
 status register and line status flags. Assumes the register bus delivers
 one-cycle read and write strobes per register and that the FIFOs,
 receiver and transmitter supply their status as synchronous levels/pulses.
*/
// Notes on behaviour
// - FIFO mode, receive enabled: interrupt at trigger level, drops below it.
// - Data ready flag set on character into FIFO, cleared when FIFO empty.
// - FIFOs on with enables 0-3 clear gives polled mode via line status, except general input toggles.
// - Line status: overrun, head error type, holding empty, all transmit empty.
// - Line status bit 7 set while any FIFO character has error or break.
// - Receive ready on held character, or FIFO trigger reached in FIFO mode.
// - Transmit ready raised at once if holding empty when enable is set.
// - Line status interrupt on bits 1-4 or 7, held while bit 7 set.
// - Overrun interrupt raised immediately when the overrunning character arrives.
// - Modem status interrupt from any of modem status bits 0 to 3.
// - Enable bits 4-7 writable only with enhanced bit 4; all reset zero.
// - Interrupt on rising request-to-send output and rising clear-to-send input.
// - Timeout after four characters plus twelve bits; cleared by holding read.
// - Transmit ready on empty, free space above trigger, or half-duplex empty.
// - General input toggle raises interrupt; input level register read clears.
// - Per-source clearing: errors read, below trigger, status read or write, modem read.
// - Xoff cleared by Xon; special by status read; flow pins by modem read.
// - Six-bit codes for priorities 1 to 8; idle code 000001.
// - Status read returns highest pending; code frozen until that one serviced.
// - Status bit 0 low while pending, high when idle, high after reset.
// - Status bit 4 for Xoff or special match with enhanced and enable 5.
// - Bit 5 flow pin change with enhanced; bits 7:6 mirror FIFO enable.
`timescale 1ns/1ps
module uip_core
   import uip_pkg::*;
#(
   parameter int GPIO_W = UIP_GPIO_W
)
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // Register access
   input wire logic IER_WR,
   input wire logic [7:0] IER_WDATA,
   output logic [7:0] IER_RDATA,
   input wire logic ISR_RD,
   output logic [7:0] ISR_RDATA,
   output logic [7:0] LSR_RDATA,
   input wire logic RHR_RD,
   input wire logic THR_WR,
   input wire logic MSR_RD,
   input wire logic GPIO_LEVEL_RD,
   // Configuration from neighbouring registers
   input wire logic FIFO_EN,
   input wire logic ENH_EN,
   input wire logic AUTO_RTS_EN,
   input wire logic AUTO_CTS_EN,
   // Event sources
   input wire uip_rx_s RX_STAT,
   input wire uip_tx_s TX_STAT,
   input wire logic [3:0] MODEM_DELTA,
   input wire logic [GPIO_W-1:0] GPIO_IN,
   input wire logic XOFF_MATCH,
   input wire logic XON_MATCH,
   input wire logic SPECIAL_MATCH,
   input wire logic RTS_OUT,
   input wire logic CTS_IN,
   input wire logic BIT_TICK,
   input wire logic [3:0] CHAR_BITS,
   // Outputs
   output logic IRQ,
   output logic SLEEP_EN
);

   // ----------------------------------------------------------------
   // Enable register
   // ----------------------------------------------------------------
   logic [7:0] ier_q;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         ier_q <= UIP_IER_RESET;
      else if (IER_WR)
      begin
         ier_q[UIP_IE_BASIC_W-1:0] <= IER_WDATA[UIP_IE_BASIC_W-1:0];
         if (ENH_EN)
            ier_q[7:UIP_IE_BASIC_W] <= IER_WDATA[7:UIP_IE_BASIC_W];
      end
   end

   assign IER_RDATA = ier_q;
   assign SLEEP_EN = ier_q[UIP_IE_SLEEP];

   // ----------------------------------------------------------------
   // Line status
   // ----------------------------------------------------------------
   logic overrun_q;
   logic [7:0] line_status_reg;

   logic lsr_rd_clr;
   // Overrun clears once the offending data has been drained
   assign lsr_rd_clr = !RX_STAT.fifo_nonempty;

   // Overrun is caught at arrival, not when the character reaches the head
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         overrun_q <= 1'b0;
      else if (RX_STAT.overrun_pulse)
         overrun_q <= 1'b1;
      else if (lsr_rd_clr)
         overrun_q <= 1'b0;
   end

   always_comb
   begin
      line_status_reg = 8'h00;
      line_status_reg[UIP_LS_DR] = RX_STAT.fifo_nonempty;
      line_status_reg[UIP_LS_OE] = overrun_q;
      line_status_reg[UIP_LS_PE] = RX_STAT.head_pe;
      line_status_reg[UIP_LS_FE] = RX_STAT.head_fe;
      line_status_reg[UIP_LS_BI] = RX_STAT.head_bi;
      line_status_reg[UIP_LS_THRE] = TX_STAT.thr_empty;
      line_status_reg[UIP_LS_TEMT] = TX_STAT.tx_all_empty;
      line_status_reg[UIP_LS_FERR] = RX_STAT.any_err;
   end

   assign LSR_RDATA = line_status_reg;

   // ----------------------------------------------------------------
   // Receive timeout
   // ----------------------------------------------------------------
   logic tmo_exp;
   logic tmo_q;

   uip_timeout u_timeout (
      .SYS_CLK(SYS_CLK),
      .RSTN(RSTN),
      .bit_tick(BIT_TICK),
      .char_bits(CHAR_BITS),
      .fifo_nonempty(RX_STAT.fifo_nonempty),
      .activity(RHR_RD || RX_STAT.char_pulse),
      .expired(tmo_exp)
   );

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         tmo_q <= 1'b0;
      else if (tmo_exp && FIFO_EN)
         tmo_q <= 1'b1;
      else if (RHR_RD)
         tmo_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Transmit ready: set on empty edge, on enable rise, cleared by access
   // ----------------------------------------------------------------
   logic tx_cond;
   logic tx_cond_q;
   logic tx_q;
   logic ie_tx_rise;
   uip_src_e cur_src_q;

   assign tx_cond = TX_STAT.auto_485 ? TX_STAT.tx_all_empty
                  : (FIFO_EN ? TX_STAT.space_above_trig : TX_STAT.thr_empty);
   assign ie_tx_rise = IER_WR && IER_WDATA[UIP_IE_TX] && !ier_q[UIP_IE_TX];

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         tx_cond_q <= 1'b0;
      else
         tx_cond_q <= tx_cond;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         tx_q <= 1'b0;
      else if ((tx_cond && !tx_cond_q) || (ie_tx_rise && tx_cond))
         tx_q <= 1'b1;
      else if (THR_WR || (ISR_RD && cur_src_q == UIP_SRC_TX))
         tx_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Modem, general input, Xoff/special and flow pin sticky flags
   // ----------------------------------------------------------------
   logic ms_q;
   logic [GPIO_W-1:0] gpio_prev_q;
   logic gpio_q;
   logic xoff_q;
   logic spec_q;
   logic rts_prev_q;
   logic cts_prev_q;
   logic flow_q;
   logic flow_ev;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         ms_q <= 1'b0;
      else if (|MODEM_DELTA)
         ms_q <= 1'b1;
      else if (MSR_RD)
         ms_q <= 1'b0;
   end

   always_ff @(posedge SYS_CLK)
   begin
      // Loaded in reset too, so a pin idling high gives no false toggle
      gpio_prev_q <= GPIO_IN;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         gpio_q <= 1'b0;
      else if (|(GPIO_IN ^ gpio_prev_q))
         gpio_q <= 1'b1;
      else if (GPIO_LEVEL_RD)
         gpio_q <= 1'b0;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         xoff_q <= 1'b0;
      else if (XOFF_MATCH)
         xoff_q <= 1'b1;
      else if (XON_MATCH)
         xoff_q <= 1'b0;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         spec_q <= 1'b0;
      else if (SPECIAL_MATCH)
         spec_q <= 1'b1;
      else if (ISR_RD && cur_src_q == UIP_SRC_XOFF)
         spec_q <= 1'b0;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         rts_prev_q <= 1'b0;
         cts_prev_q <= 1'b0;
      end
      else
      begin
         rts_prev_q <= RTS_OUT;
         cts_prev_q <= CTS_IN;
      end
   end

   assign flow_ev = (AUTO_RTS_EN && ier_q[UIP_IE_RTS] && RTS_OUT && !rts_prev_q)
                 || (AUTO_CTS_EN && ier_q[UIP_IE_CTS] && CTS_IN && !cts_prev_q);

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         flow_q <= 1'b0;
      else if (flow_ev)
         flow_q <= 1'b1;
      else if (MSR_RD)
         flow_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Requests, gated by enables except general input, and priority selection
   // ----------------------------------------------------------------
   logic req_ls, req_tmo, req_rx, req_tx, req_ms, req_gpio, req_xoff, req_flow;
   logic rx_level;

   // Non-FIFO mode: a single held character counts as reaching trigger
   assign rx_level = FIFO_EN ? RX_STAT.at_trigger : RX_STAT.fifo_nonempty;
   assign req_ls = ier_q[UIP_IE_LS] && (|line_status_reg[UIP_LS_BI:UIP_LS_OE] || line_status_reg[UIP_LS_FERR]);
   assign req_tmo = ier_q[UIP_IE_RX] && tmo_q;
   assign req_rx = ier_q[UIP_IE_RX] && rx_level;
   assign req_tx = ier_q[UIP_IE_TX] && tx_q;
   assign req_ms = ier_q[UIP_IE_MS] && ms_q;
   assign req_gpio = gpio_q;
   assign req_xoff = ENH_EN && ier_q[UIP_IE_XOFF] && (xoff_q || spec_q);
   assign req_flow = ENH_EN && flow_q;

   function automatic uip_src_e pick(input logic [7:0] r);
      uip_src_e s;
      s = UIP_SRC_NONE;
      if (r[0]) s = UIP_SRC_LS;
      else if (r[1]) s = UIP_SRC_TMO;
      else if (r[2]) s = UIP_SRC_RX;
      else if (r[3]) s = UIP_SRC_TX;
      else if (r[4]) s = UIP_SRC_MS;
      else if (r[5]) s = UIP_SRC_GPIO;
      else if (r[6]) s = UIP_SRC_XOFF;
      else if (r[7]) s = UIP_SRC_FLOW;
      return s;
   endfunction

   function automatic logic [5:0] code_of(input uip_src_e s);
      logic [5:0] c;
      c = UIP_ISR_IDLE;
      unique case (s)
         UIP_SRC_NONE: c = UIP_ISR_IDLE;
         UIP_SRC_LS: c = UIP_CODE_LS;
         UIP_SRC_TMO: c = UIP_CODE_TMO;
         UIP_SRC_RX: c = UIP_CODE_RX;
         UIP_SRC_TX: c = UIP_CODE_TX;
         UIP_SRC_MS: c = UIP_CODE_MS;
         UIP_SRC_GPIO: c = UIP_CODE_GPIO;
         UIP_SRC_XOFF: c = UIP_CODE_XOFF;
         UIP_SRC_FLOW: c = UIP_CODE_FLOW;
         default: c = UIP_ISR_IDLE;
      endcase
      return c;
   endfunction

   logic [7:0] req_vec;
   logic [7:0] pend_vec;
   uip_src_e best;

   assign req_vec = {req_flow, req_xoff, req_gpio, req_ms, req_tx, req_rx, req_tmo, req_ls};
   assign best = pick(req_vec);
   // Is the currently reported source still pending?
   assign pend_vec = req_vec;

   // Reported source holds until its request goes away
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
         cur_src_q <= UIP_SRC_NONE;
      else if (cur_src_q == UIP_SRC_NONE || !src_pending(cur_src_q, pend_vec))
         cur_src_q <= best;
   end

   function automatic logic src_pending(input uip_src_e s, input logic [7:0] r);
      logic p;
      p = 1'b0;
      if (s != UIP_SRC_NONE)
         p = r[int'(s) - 1];
      return p;
   endfunction

   assign ISR_RDATA = {{2{FIFO_EN}}, code_of(cur_src_q)};
   assign IRQ = (cur_src_q != UIP_SRC_NONE);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_IER_HIGH_LOCK: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      IER_WR && !ENH_EN |=> ier_q[7:4] == $past(ier_q[7:4]))
      else $error("upper enable bits changed without enhanced mode");
   AST_OVR_IMM: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      RX_STAT.overrun_pulse |=> line_status_reg[UIP_LS_OE])
      else $error("overrun flag not set on arrival");
   AST_IDLE_BIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ISR_RDATA[0] == !IRQ)
      else $error("idle bit disagrees with interrupt");
   AST_TX_ON_ENABLE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ie_tx_rise && tx_cond |=> tx_q)
      else $error("transmit ready not raised on enable");
   AST_TMO_CLR: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      RHR_RD && !(tmo_exp && FIFO_EN) |=> !tmo_q)
      else $error("timeout not cleared by holding read");
   AST_MS_CLR: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      MSR_RD && !(|MODEM_DELTA) |=> !ms_q)
      else $error("modem flag not cleared by read");
   AST_GPIO_SET: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      GPIO_IN != gpio_prev_q |=> gpio_q)
      else $error("input toggle missed");
   AST_FIFO_BITS: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ISR_RDATA[7:6] == {2{FIFO_EN}})
      else $error("fifo status bits wrong");
   AST_LS_PRIO: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      cur_src_q == UIP_SRC_NONE && req_ls |=> ISR_RDATA[5:0] == UIP_CODE_LS)
      else $error("line status not top priority");
   AST_FERR_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ier_q[UIP_IE_LS] && RX_STAT.any_err |-> req_ls)
      else $error("line status request dropped with errored data");
   AST_RX_TRIG: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      FIFO_EN && ier_q[UIP_IE_RX] |-> req_rx == RX_STAT.at_trigger)
      else $error("receive request not tied to trigger");

endmodule // uip_core

// >>> tb/uip_host_model.sv
/*
 Host software model: drives the register strobes of the interrupt unit.
 Assumes one-cycle strobes launched at the falling edge of SYS_CLK.
*/
`timescale 1ns/1ps
module uip_host_model
   import uip_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic [7:0] ISR_RDATA,
   output logic IER_WR,
   output logic [7:0] IER_WDATA,
   output logic ISR_RD,
   output logic RHR_RD,
   output logic THR_WR,
   output logic MSR_RD,
   output logic GPIO_LEVEL_RD
);
   initial
   begin
      {IER_WR, ISR_RD, RHR_RD, THR_WR, MSR_RD, GPIO_LEVEL_RD} = 6'h00;
      IER_WDATA = 8'h00;
   end

   // Enables 0-3 cleared with FIFOs on gives polled mode, except general input toggles
   task automatic wr_ier(input logic [7:0] d);
      @(negedge SYS_CLK);
      IER_WR = 1'h1;
      IER_WDATA = d;
      @(negedge SYS_CLK);
      IER_WR = 1'h0;
      // Released data bus must not look like the last value
      IER_WDATA = ~d;
   endtask

   // Value seen by the strobe edge is the value taken here
   task automatic rd_isr(output logic [7:0] d);
      @(negedge SYS_CLK);
      d = ISR_RDATA;
      ISR_RD = 1'h1;
      @(negedge SYS_CLK);
      ISR_RD = 1'h0;
   endtask

   // One-hot: 8 holding read, 4 holding write, 2 modem read, 1 input read
   task automatic pulse(input logic [3:0] k);
      @(negedge SYS_CLK);
      {RHR_RD, THR_WR, MSR_RD, GPIO_LEVEL_RD} = k;
      @(negedge SYS_CLK);
      {RHR_RD, THR_WR, MSR_RD, GPIO_LEVEL_RD} = 4'h0;
   endtask
endmodule // uip_host_model

// >>> tb/tb.sv
/*
 Self-checking bench for the interrupt priority unit.
 Assumes the host model drives all register strobes.
*/
`timescale 1ns/1ps
module tb;
   import uip_pkg::*;
   logic clk, rstn, fifo_en, enh_en;
   logic arts, acts, xoff, xon, spec;
   logic rts, cts, tick;
   logic [3:0] mdelta, cbits;
   logic [7:0] gpio;
   uip_rx_s rx;
   uip_tx_s tx;
   logic ier_wr, isr_rd, rhr_rd, thr_wr, msr_rd, gpio_rd, irq, sleep_en;
   logic [7:0] ier_wdata, ier_rdata, isr_rdata, lsr_rdata, d;
   int fails = 0, checks_done = 0;

   always #5 clk = ~clk;

   uip_host_model i_uip_host_model (.SYS_CLK(clk), .ISR_RDATA(isr_rdata),
      .IER_WR(ier_wr), .IER_WDATA(ier_wdata), .ISR_RD(isr_rd), .RHR_RD(rhr_rd),
      .THR_WR(thr_wr), .MSR_RD(msr_rd), .GPIO_LEVEL_RD(gpio_rd));

   uip_core i_uip_core (.SYS_CLK(clk), .RSTN(rstn), .IER_WR(ier_wr),
      .IER_WDATA(ier_wdata), .IER_RDATA(ier_rdata), .ISR_RD(isr_rd),
      .ISR_RDATA(isr_rdata), .LSR_RDATA(lsr_rdata), .RHR_RD(rhr_rd),
      .THR_WR(thr_wr), .MSR_RD(msr_rd), .GPIO_LEVEL_RD(gpio_rd),
      .FIFO_EN(fifo_en), .ENH_EN(enh_en), .AUTO_RTS_EN(arts), .AUTO_CTS_EN(acts),
      .RX_STAT(rx), .TX_STAT(tx), .MODEM_DELTA(mdelta), .GPIO_IN(gpio),
      .XOFF_MATCH(xoff), .XON_MATCH(xon), .SPECIAL_MATCH(spec), .RTS_OUT(rts),
      .CTS_IN(cts), .BIT_TICK(tick), .CHAR_BITS(cbits), .IRQ(irq),
      .SLEEP_EN(sleep_en));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Answer is at most two cycles after the cause
   task automatic isr_is(input logic [5:0] c, input logic q);
      repeat (3) @(negedge clk);
      check("isr", isr_rdata, {fifo_en, fifo_en, c});
      check("irq", {7'h00, irq}, {7'h00, q});
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_enable;
      check("ier reset", ier_rdata, UIP_IER_RESET);
      isr_is(UIP_ISR_IDLE, 1'h0);
      i_uip_host_model.wr_ier(8'hf0);
      check("ier locked", ier_rdata, 8'h00);
      enh_en = 1'h1;
      i_uip_host_model.wr_ier(8'h10);
      check("ier open", ier_rdata, 8'h10);
      check("sleep", {7'h00, sleep_en}, 8'h01);
      i_uip_host_model.wr_ier(8'h00);
      enh_en = 1'h0;
   endtask

   task automatic t_modem;
      i_uip_host_model.wr_ier(8'h08);
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         mdelta = 4'h1 << i;
         @(negedge clk);
         mdelta = 4'h0;
         isr_is(UIP_CODE_MS, 1'h1);
         i_uip_host_model.pulse(4'h2);
         isr_is(UIP_ISR_IDLE, 1'h0);
      end
   endtask

   task automatic t_prio;
      fifo_en = 1'h1;
      i_uip_host_model.wr_ier(8'h0d);
      @(negedge clk);
      rx.fifo_nonempty = 1'h1;
      rx.at_trigger = 1'h1;
      rx.any_err = 1'h1;
      rx.head_bi = 1'h1;
      mdelta = 4'h1;
      @(negedge clk);
      mdelta = 4'h0;
      isr_is(UIP_CODE_LS, 1'h1);
      rx.any_err = 1'h0;
      isr_is(UIP_CODE_LS, 1'h1);
      rx.head_bi = 1'h0;
      isr_is(UIP_CODE_RX, 1'h1);
      rx.at_trigger = 1'h0;
      isr_is(UIP_CODE_MS, 1'h1);
      i_uip_host_model.pulse(4'h2);
      rx = '0;
      isr_is(UIP_ISR_IDLE, 1'h0);
      fifo_en = 1'h0;
      i_uip_host_model.wr_ier(8'h00);
   endtask

   task automatic t_tx;
      tx.thr_empty = 1'h1;
      isr_is(UIP_ISR_IDLE, 1'h0);
      i_uip_host_model.wr_ier(8'h02);
      isr_is(UIP_CODE_TX, 1'h1);
      i_uip_host_model.rd_isr(d);
      check("isr read", d, {2'h0, UIP_CODE_TX});
      isr_is(UIP_ISR_IDLE, 1'h0);
      tx.thr_empty = 1'h0;
      repeat (2) @(negedge clk);
      tx.thr_empty = 1'h1;
      isr_is(UIP_CODE_TX, 1'h1);
      i_uip_host_model.pulse(4'h4);
      isr_is(UIP_ISR_IDLE, 1'h0);
      tx = '0;
      fifo_en = 1'h1;
      @(negedge clk);
      tx.space_above_trig = 1'h1;
      isr_is(UIP_CODE_TX, 1'h1);
      i_uip_host_model.pulse(4'h4);
      tx = '{default: 1'h0, auto_485: 1'h1};
      @(negedge clk);
      tx.tx_all_empty = 1'h1;
      isr_is(UIP_CODE_TX, 1'h1);
      i_uip_host_model.rd_isr(d);
      check("isr read fifo", d, {2'h3, UIP_CODE_TX});
      isr_is(UIP_ISR_IDLE, 1'h0);
      tx = '0;
      fifo_en = 1'h0;
      i_uip_host_model.wr_ier(8'h00);
   endtask

   task automatic t_gpio;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         gpio = gpio ^ (8'h01 << i);
         isr_is(UIP_CODE_GPIO, 1'h1);
         i_uip_host_model.pulse(4'h1);
         isr_is(UIP_ISR_IDLE, 1'h0);
      end
   endtask

   task automatic t_polled;
      fifo_en = 1'h1;
      @(negedge clk);
      rx.fifo_nonempty = 1'h1;
      rx.at_trigger = 1'h1;
      rx.head_pe = 1'h1;
      rx.head_fe = 1'h1;
      rx.any_err = 1'h1;
      tx.thr_empty = 1'h1;
      tx.tx_all_empty = 1'h1;
      isr_is(UIP_ISR_IDLE, 1'h0);
      check("lsr", lsr_rdata, 8'hed);
      rx.overrun_pulse = 1'h1;
      @(negedge clk);
      rx.overrun_pulse = 1'h0;
      repeat (2) @(negedge clk);
      check("lsr ovr", lsr_rdata, 8'hef);
      i_uip_host_model.wr_ier(8'h04);
      isr_is(UIP_CODE_LS, 1'h1);
      rx = '0;
      isr_is(UIP_ISR_IDLE, 1'h0);
      check("lsr idle", lsr_rdata, 8'h60);
      tx = '0;
      fifo_en = 1'h0;
      i_uip_host_model.wr_ier(8'h00);
   endtask

   task automatic t_xoff;
      enh_en = 1'h1;
      i_uip_host_model.wr_ier(8'h20);
      @(negedge clk);
      xoff = 1'h1;
      @(negedge clk);
      xoff = 1'h0;
      isr_is(UIP_CODE_XOFF, 1'h1);
      i_uip_host_model.rd_isr(d);
      isr_is(UIP_CODE_XOFF, 1'h1);
      xon = 1'h1;
      @(negedge clk);
      xon = 1'h0;
      isr_is(UIP_ISR_IDLE, 1'h0);
      spec = 1'h1;
      @(negedge clk);
      spec = 1'h0;
      isr_is(UIP_CODE_XOFF, 1'h1);
      i_uip_host_model.rd_isr(d);
      isr_is(UIP_ISR_IDLE, 1'h0);
   endtask

   task automatic t_flow;
      arts = 1'h1;
      acts = 1'h1;
      i_uip_host_model.wr_ier(8'hc0);
      rts = 1'h1;
      isr_is(UIP_CODE_FLOW, 1'h1);
      i_uip_host_model.pulse(4'h2);
      isr_is(UIP_ISR_IDLE, 1'h0);
      rts = 1'h0;
      cts = 1'h1;
      isr_is(UIP_CODE_FLOW, 1'h1);
      i_uip_host_model.pulse(4'h2);
      cts = 1'h0;
      isr_is(UIP_ISR_IDLE, 1'h0);
      i_uip_host_model.wr_ier(8'h00);
      {enh_en, arts, acts} = 3'h0;
   endtask

   // Tick every cycle, two bits per character; an arrival restarts the timer
   task automatic t_tmo;
      int lim;
      lim = UIP_TMO_CHARS * 2 + UIP_TMO_EXTRA_BITS;
      fifo_en = 1'h1;
      cbits = 4'h2;
      i_uip_host_model.wr_ier(8'h01);
      rx.fifo_nonempty = 1'h1;
      tick = 1'h1;
      repeat (10) @(negedge clk);
      rx.char_pulse = 1'h1;
      @(negedge clk);
      rx.char_pulse = 1'h0;
      // Flag on the tick that reaches the limit, interrupt one cycle later
      repeat (lim) @(negedge clk);
      check("early", {7'h00, irq}, 8'h00);
      @(negedge clk);
      check("tmo irq", {7'h00, irq}, 8'h01);
      isr_is(UIP_CODE_TMO, 1'h1);
      i_uip_host_model.pulse(4'h8);
      isr_is(UIP_ISR_IDLE, 1'h0);
      rx = '0;
      tick = 1'h0;
   endtask

   initial
   begin
      {clk, rstn, fifo_en, enh_en, arts, acts, xoff, xon, spec, rts, cts, tick} = 12'h000;
      mdelta = 4'h0;
      cbits = 4'h1;
      gpio = 8'h00;
      rx = '0;
      tx = '0;
      repeat (6) @(negedge clk);
      rstn = 1'h1;
      t_enable;
      t_modem;
      t_prio;
      t_tx;
      t_gpio;
      t_polled;
      t_xoff;
      t_flow;
      t_tmo;
      tally_and_finish;
   end

   // Whole run needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish;
   end
endmodule // tb
